// file: cga_pkg.sv
// Purpose: shared constants and operation codes for the general ALU
// Assumes: 32-bit operands, 5-bit immediates
// Notes:   operation codes are local to this unit, not instruction bits
package cga_pkg;

  localparam int          CGA_DATA_W      = 32;
  localparam int          CGA_SHAMT_W     = 5;
  localparam int          CGA_OP_W        = 6;
  localparam int          CGA_HALF_MSB    = 15;
  localparam int          CGA_BYTE_MSB    = 7;
  localparam int          CGA_LATENCY     = 1;
  localparam logic [31:0] CGA_RESULT_RST  = 32'h0000_0000;
  localparam logic [31:0] CGA_ONE         = 32'h0000_0001;
  localparam logic [31:0] CGA_ALL_ONES    = 32'hFFFF_FFFF;
  localparam logic [4:0]  CGA_AVG_SHIFT   = 5'h01;

  typedef enum logic [5:0] {
    absolute_value_op           = 6'h00,
    set_less_equal_signed_op    = 6'h01,
    set_less_equal_unsigned_op  = 6'h02,
    minimum_signed_op           = 6'h03,
    minimum_unsigned_op         = 6'h04,
    maximum_signed_op           = 6'h05,
    maximum_unsigned_op         = 6'h06,
    half_sign_extend_op         = 6'h07,
    half_zero_extend_op         = 6'h08,
    byte_sign_extend_op         = 6'h09,
    byte_zero_extend_op         = 6'h0A,
    signed_clip_imm_op          = 6'h0B,
    unsigned_clip_imm_op        = 6'h0C,
    signed_clip_reg_op          = 6'h0D,
    unsigned_clip_reg_op        = 6'h0E,
    add_shift_signed_op         = 6'h10,
    add_shift_unsigned_op       = 6'h11,
    add_round_shift_signed_op   = 6'h12,
    add_round_shift_unsigned_op = 6'h13,
    sub_shift_signed_op         = 6'h14,
    sub_shift_unsigned_op       = 6'h15,
    sub_round_shift_signed_op   = 6'h16,
    sub_round_shift_unsigned_op = 6'h17,
    acc_add_shift_signed_op     = 6'h18,
    acc_add_shift_unsigned_op   = 6'h19,
    acc_add_round_signed_op     = 6'h1A,
    acc_add_round_unsigned_op   = 6'h1B,
    acc_sub_shift_signed_op     = 6'h1C,
    acc_sub_shift_unsigned_op   = 6'h1D,
    acc_sub_round_signed_op     = 6'h1E,
    acc_sub_round_unsigned_op   = 6'h1F,
    legacy_average_signed_op    = 6'h20,
    legacy_average_unsigned_op  = 6'h21
  } cga_op_t;

endpackage

// file: cga_custom_general_alu.sv
// Purpose: datapath for the custom general arithmetic operations
// Assumes: operands come from decode and register file, same clock
// Notes:   one-cycle latency, no back-pressure; a result per valid op
`timescale 1ns/100ps

module cga_custom_general_alu
  import cga_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  input  wire logic                  opValid,
  input  wire cga_op_t               opCode,
  input  wire logic [CGA_DATA_W-1:0] srcFirst,
  input  wire logic [CGA_DATA_W-1:0] srcSecond,
  input  wire logic [CGA_DATA_W-1:0] srcDest,
  input  wire logic [4:0]            immValue,
  output logic                       resultValid,
  output logic [CGA_DATA_W-1:0]      result,
  output logic                       opIllegal
);

  // half-step for rounding; zero shift must add nothing
  function automatic logic [31:0] roundTerm(input logic [4:0] amount);
    logic [31:0] term;
    term = 32'h0000_0000;
    if (amount != 5'h00) begin
      term = CGA_ONE << 5'(amount - 5'h01);
    end
    return term;
  endfunction

  function automatic logic [31:0] shiftRight(input logic [31:0] value,
                                             input logic [4:0]  amount,
                                             input logic        arith);
    logic [31:0] shifted;
    shifted = value >> amount;
    if (arith) begin
      shifted = $signed(value) >>> amount;
    end
    return shifted;
  endfunction

  function automatic logic lessThan(input logic [31:0] a,
                                    input logic [31:0] b,
                                    input logic        isSigned);
    logic lt;
    lt = a < b;
    if (isSigned) begin
      lt = $signed(a) < $signed(b);
    end
    return lt;
  endfunction

  // saturate a signed value between two signed bounds
  function automatic logic [31:0] clipTo(input logic [31:0] value,
                                         input logic [31:0] lower,
                                         input logic [31:0] upper);
    logic [31:0] clipped;
    clipped = value;
    if ($signed(value) <= $signed(lower)) begin
      clipped = lower;
    end else if ($signed(value) >= $signed(upper)) begin
      clipped = upper;
    end
    return clipped;
  endfunction

  logic [31:0] clipLower;
  logic [31:0] clipUpper;
  logic [31:0] immRound;
  logic [31:0] regRound;
  logic [4:0]  regShift;
  logic [31:0] next_result;
  logic        next_illegal;

  always_comb begin
    clipLower = CGA_ALL_ONES;
    clipUpper = 32'h0000_0000;
    if (immValue != 5'h00) begin
      clipLower = CGA_ALL_ONES << 5'(immValue - 5'h01);
      clipUpper = ~clipLower;
    end
  end

  assign immRound = roundTerm(immValue);
  assign regShift = srcSecond[4:0];
  assign regRound = roundTerm(regShift);

  always_comb begin
    next_result  = 32'h0000_0000;
    next_illegal = 1'b0;
    case (opCode)
      absolute_value_op: begin
        next_result = srcFirst[31] ? 32'(-srcFirst) : srcFirst;
      end
      set_less_equal_signed_op: begin
        next_result = {31'h0, !lessThan(srcSecond, srcFirst, 1'b1)};
      end
      set_less_equal_unsigned_op: begin
        next_result = {31'h0, !lessThan(srcSecond, srcFirst, 1'b0)};
      end
      minimum_signed_op: begin
        next_result = lessThan(srcFirst, srcSecond, 1'b1) ?
                      srcFirst : srcSecond;
      end
      minimum_unsigned_op: begin
        next_result = lessThan(srcFirst, srcSecond, 1'b0) ?
                      srcFirst : srcSecond;
      end
      maximum_signed_op: begin
        next_result = lessThan(srcFirst, srcSecond, 1'b1) ?
                      srcSecond : srcFirst;
      end
      maximum_unsigned_op: begin
        next_result = lessThan(srcFirst, srcSecond, 1'b0) ?
                      srcSecond : srcFirst;
      end
      half_sign_extend_op: begin
        next_result = {{16{srcFirst[CGA_HALF_MSB]}},
                       srcFirst[CGA_HALF_MSB:0]};
      end
      half_zero_extend_op: begin
        next_result = {16'h0000, srcFirst[CGA_HALF_MSB:0]};
      end
      byte_sign_extend_op: begin
        next_result = {{24{srcFirst[CGA_BYTE_MSB]}},
                       srcFirst[CGA_BYTE_MSB:0]};
      end
      byte_zero_extend_op: begin
        next_result = {24'h00_0000, srcFirst[CGA_BYTE_MSB:0]};
      end
      signed_clip_imm_op: begin
        next_result = clipTo(srcFirst, clipLower, clipUpper);
      end
      unsigned_clip_imm_op: begin
        next_result = clipTo(srcFirst, 32'h0000_0000, clipUpper);
      end
      // signed register clip, lower bound is ~rs2
      signed_clip_reg_op: begin
        next_result = clipTo(srcFirst, ~srcSecond, srcSecond);
      end
      unsigned_clip_reg_op: begin
        next_result = clipTo(srcFirst, 32'h0000_0000, srcSecond);
      end
      add_shift_signed_op: begin
        next_result = shiftRight(32'(srcFirst + srcSecond), immValue, 1'b1);
      end
      add_shift_unsigned_op: begin
        next_result = shiftRight(32'(srcFirst + srcSecond), immValue, 1'b0);
      end
      // old averages are the shift-by-one case
      legacy_average_signed_op: begin
        next_result = shiftRight(32'(srcFirst + srcSecond),
                                 CGA_AVG_SHIFT, 1'b1);
      end
      legacy_average_unsigned_op: begin
        next_result = shiftRight(32'(srcFirst + srcSecond),
                                 CGA_AVG_SHIFT, 1'b0);
      end
      add_round_shift_signed_op: begin
        next_result = shiftRight(32'(srcFirst + srcSecond + immRound),
                                 immValue, 1'b1);
      end
      add_round_shift_unsigned_op: begin
        next_result = shiftRight(32'(srcFirst + srcSecond + immRound),
                                 immValue, 1'b0);
      end
      sub_shift_signed_op: begin
        next_result = shiftRight(32'(srcFirst - srcSecond), immValue, 1'b1);
      end
      sub_shift_unsigned_op: begin
        next_result = shiftRight(32'(srcFirst - srcSecond), immValue, 1'b0);
      end
      sub_round_shift_signed_op: begin
        next_result = shiftRight(32'(srcFirst - srcSecond + immRound),
                                 immValue, 1'b1);
      end
      sub_round_shift_unsigned_op: begin
        next_result = shiftRight(32'(srcFirst - srcSecond + immRound),
                                 immValue, 1'b0);
      end
      acc_add_shift_signed_op: begin
        next_result = shiftRight(32'(srcDest + srcFirst), regShift, 1'b1);
      end
      acc_add_shift_unsigned_op: begin
        next_result = shiftRight(32'(srcDest + srcFirst), regShift, 1'b0);
      end
      acc_add_round_signed_op: begin
        next_result = shiftRight(32'(srcDest + srcFirst + regRound),
                                 regShift, 1'b1);
      end
      acc_add_round_unsigned_op: begin
        next_result = shiftRight(32'(srcDest + srcFirst + regRound),
                                 regShift, 1'b0);
      end
      acc_sub_shift_signed_op: begin
        next_result = shiftRight(32'(srcDest - srcFirst), regShift, 1'b1);
      end
      acc_sub_shift_unsigned_op: begin
        next_result = shiftRight(32'(srcDest - srcFirst), regShift, 1'b0);
      end
      acc_sub_round_signed_op: begin
        next_result = shiftRight(32'(srcDest - srcFirst + regRound),
                                 regShift, 1'b1);
      end
      acc_sub_round_unsigned_op: begin
        next_result = shiftRight(32'(srcDest - srcFirst + regRound),
                                 regShift, 1'b0);
      end
      // unknown code gives zero and a flag, never a stale value
      default: begin
        next_result  = 32'h0000_0000;
        next_illegal = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      resultValid <= 1'b0;
    end else begin
      resultValid <= opValid;
    end
  end

  // result holds between ops so the core may sample it late
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      result    <= CGA_RESULT_RST;
      opIllegal <= 1'b0;
    end else if (opValid) begin
      result    <= next_result;
      opIllegal <= next_illegal;
    end
  end

endmodule

// file: cga_alu_properties.sv
// Purpose: port checks of the general alu, bound to its top module
// Assumes: one clock, async active-low reset, one-cycle answer
// Notes:   values are read one edge after the taking edge via $past
`timescale 1ns/100ps
module cga_alu_properties
  import cga_pkg::*;
(
  input wire logic                  clk_sys,
  input wire logic                  arst_n,
  input wire logic                  opValid,
  input wire cga_op_t               opCode,
  input wire logic [CGA_DATA_W-1:0] srcFirst,
  input wire logic [CGA_DATA_W-1:0] srcSecond,
  input wire logic [CGA_DATA_W-1:0] srcDest,
  input wire logic [4:0]            immValue,
  input wire logic                  resultValid,
  input wire logic [CGA_DATA_W-1:0] result,
  input wire logic                  opIllegal
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence took(cga_op_t op);
    opValid && opCode == op;
  endsequence
  answer_latency_a: assert property (opValid |=> resultValid)
    else $error("no result one cycle after a taken op");
  idle_hold_a: assert property (!opValid |=> !resultValid
    && $stable(result) && $stable(opIllegal))
    else $error("result moved without a taken op");
  abs_value_a: assert property (took(absolute_value_op) |=>
    result == ($past(srcFirst[31]) ? -$past(srcFirst) : $past(srcFirst)))
    else $error("absolute value wrong");
  sle_signed_a: assert property (took(set_less_equal_signed_op) |=>
    result == {31'h0, $signed($past(srcFirst)) <= $signed($past(srcSecond))})
    else $error("signed set-less-equal wrong");
  min_unsigned_a: assert property (took(minimum_unsigned_op) |=>
    result == ($past(srcFirst) < $past(srcSecond) ? $past(srcFirst)
    : $past(srcSecond))) else $error("unsigned minimum wrong");
  max_signed_a: assert property (took(maximum_signed_op) |=>
    result == ($signed($past(srcFirst)) < $signed($past(srcSecond))
    ? $past(srcSecond) : $past(srcFirst))) else $error("signed max wrong");
  byte_zero_a: assert property (took(byte_zero_extend_op) |=>
    result == {24'h0, $past(srcFirst[7:0])}) else $error("byte zext wrong");
  clip_zero_a: assert property (took(signed_clip_imm_op) ##0
    immValue == 5'h00 |=> result == ($past(srcFirst[31]) ? CGA_ALL_ONES
    : CGA_RESULT_RST)) else $error("zero-width clip wrong");
  round_zero_a: assert property (took(add_round_shift_signed_op) ##0
    immValue == 5'h00 |=> result == $past(srcFirst) + $past(srcSecond))
    else $error("zero-shift rounding not zero");
  known_code_a: assert property (opValid && opCode <= 6'h0E |=> !opIllegal)
    else $error("known code flagged illegal");
endmodule

bind cga_custom_general_alu cga_alu_properties u_cga_alu_properties (
  .clk_sys(clk_sys), .arst_n(arst_n), .opValid(opValid), .opCode(opCode),
  .srcFirst(srcFirst), .srcSecond(srcSecond), .srcDest(srcDest),
  .immValue(immValue), .resultValid(resultValid), .result(result),
  .opIllegal(opIllegal));

// file: cga_operand_source.sv
// Purpose: decode and register-file side that presents operands
// Assumes: requests come from the bench just after a falling edge
// Notes:   idle operand lines show the inverse of the last value sent
`timescale 1ns/100ps
module cga_operand_source
  import cga_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reqValid,
  input  wire logic [5:0]  reqCode,
  input  wire logic [31:0] reqFirst,
  input  wire logic [31:0] reqSecond,
  input  wire logic [31:0] reqDest,
  input  wire logic [4:0]  reqImm,
  output logic             opValid,
  output cga_op_t          opCode,
  output logic [31:0]      srcFirst,
  output logic [31:0]      srcSecond,
  output logic [31:0]      srcDest,
  output logic [4:0]       immValue
);
  logic [106:0] lastSent = '0;
  logic [5:0]   codeBits;
  // stale lines must not look valid, so idle shows the inverse
  always_ff @(posedge clk_sys) begin
    if (reqValid) begin
      lastSent <= {reqCode, reqFirst, reqSecond, reqDest, reqImm};
    end
  end
  assign opValid = reqValid;
  // the enum takes its code by cast, never from a bare concatenation
  assign opCode = cga_op_t'(codeBits);
  assign {codeBits, srcFirst, srcSecond, srcDest, immValue} = reqValid
    ? {reqCode, reqFirst, reqSecond, reqDest, reqImm} : ~lastSent;
endmodule

// file: custom_general_alu_bench.sv
// Purpose: self-checking bench of the general alu
// Assumes: inputs change at falling edges, answer one cycle later
// Notes:   random operands come from a fixed-start lfsr
`timescale 1ns/100ps
module custom_general_alu_bench;
  import cga_pkg::*;
  logic clk_sys = 1'b0, arst_n = 1'b0, reqValid = 1'b0, resultValid;
  logic opValid, opIllegal, expValid = 1'b0, expIll;
  logic [5:0]  reqCode = 6'h00;
  logic [4:0]  reqImm = 5'h00, immValue;
  logic [31:0] reqFirst = '0, reqSecond = '0, reqDest = '0, rnd = 32'h18;
  logic [31:0] srcFirst, srcSecond, srcDest, result, expRes = '0;
  cga_op_t     opCode;
  int          err_total = 0, n_compared = 0;
  always #2.5 clk_sys = ~clk_sys;
  cga_operand_source u_cga_operand_source (.clk_sys(clk_sys),
    .reqValid(reqValid), .reqCode(reqCode), .reqFirst(reqFirst),
    .reqSecond(reqSecond), .reqDest(reqDest), .reqImm(reqImm),
    .opValid(opValid), .opCode(opCode), .srcFirst(srcFirst),
    .srcSecond(srcSecond), .srcDest(srcDest), .immValue(immValue));
  cga_custom_general_alu u_cga_custom_general_alu (.clk_sys(clk_sys),
    .arst_n(arst_n), .opValid(opValid), .opCode(opCode),
    .srcFirst(srcFirst), .srcSecond(srcSecond), .srcDest(srcDest),
    .immValue(immValue), .resultValid(resultValid), .result(result),
    .opIllegal(opIllegal));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic known(input logic [5:0] c);
    return c <= 6'h0E || (c >= 6'h10 && c <= 6'h21);
  endfunction
  function automatic logic [31:0] model(input logic [5:0] c,
    input logic [31:0] a, b, d, input logic [4:0] im);
    logic [31:0] lo, hi, x, s;
    logic [4:0]  n;
    lo = (im == 5'h00) ? CGA_ALL_ONES : -(CGA_ONE << (im - 5'h01));
    hi = (im == 5'h00) ? '0 : (CGA_ONE << (im - 5'h01)) - CGA_ONE;
    if (c == 6'h0C) lo = '0;
    if (c == 6'h0D) {lo, hi} = {~b, b};
    if (c == 6'h0E) {lo, hi} = {32'h0, b};
    n = c[3] ? b[4:0] : (c[5] ? CGA_AVG_SHIFT : im);
    x = c[3] ? d : a;
    s = c[2] && !c[5] ? x - (c[3] ? a : b) : x + (c[3] ? a : b);
    if (c[1] && !c[5] && n != 5'h00) s = s + (CGA_ONE << (n - 5'h01));
    case (c)
      6'h00: return a[31] ? -a : a;
      6'h01: return {31'h0, $signed(a) <= $signed(b)};
      6'h02: return {31'h0, a <= b};
      6'h03: return $signed(a) < $signed(b) ? a : b;
      6'h04: return a < b ? a : b;
      6'h05: return $signed(a) < $signed(b) ? b : a;
      6'h06: return a < b ? b : a;
      6'h07: return {{16{a[15]}}, a[15:0]};
      6'h08: return {16'h0, a[15:0]};
      6'h09: return {{24{a[7]}}, a[7:0]};
      6'h0A: return {24'h0, a[7:0]};
      6'h0B, 6'h0C, 6'h0D, 6'h0E: return $signed(a) <= $signed(lo) ? lo
        : ($signed(a) >= $signed(hi) ? hi : a);
      default: begin
        // kept apart: in one ?: the unsigned arm would make >>> logical
        if (!known(c)) return '0;
        if (c[0]) return s >> n;
        return $signed(s) >>> n;
      end
    endcase
  endfunction
  task automatic check(input string name, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // checks the previous edge's answer, then presents the next request
  task automatic step(input logic v, input logic [5:0] c,
    input logic [31:0] a, b, d, input logic [4:0] im);
    @(negedge clk_sys);
    check("valid", {31'h0, resultValid}, {31'h0, expValid});
    check("result", result, expRes); // via model
    check("illegal", {31'h0, opIllegal}, {31'h0, expIll});
    if (v) {expRes, expIll} = {model(c, a, b, d, im), !known(c)};
    expValid = v;
    {reqValid, reqCode, reqFirst, reqSecond, reqDest, reqImm}
      = {v, c, a, b, d, im};
  endtask
  task automatic rstep(input logic [5:0] c);
    rnd = lfsr(rnd);
    step(1'b1, c, rnd, lfsr(rnd), ~rnd, rnd[9:5]);
  endtask
  initial begin
    #250000;
    err_total++;
    end_of_test();
  end
  initial begin
    expIll = 1'b0;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys) arst_n = 1'b1;
    step(1'b1, 6'h00, 32'h8000_0000, '0, '0, 5'h00);
    step(1'b1, 6'h01, 32'hFFFF_FFFF, 32'hFFFF_FFFF, '0, 5'h00);
    step(1'b1, 6'h02, 32'hFFFF_FFFF, 32'h1, '0, 5'h00);
    step(1'b1, 6'h03, 32'h5, 32'h5, '0, 5'h00);
    step(1'b1, 6'h06, 32'h8000_0000, 32'h1, '0, 5'h00);
    step(1'b1, 6'h07, 32'h0000_8000, '0, '0, 5'h00);
    step(1'b1, 6'h0B, 32'h0000_0007, '0, '0, 5'h00);
    step(1'b1, 6'h0B, 32'hFFFF_FF80, '0, '0, 5'h08);
    step(1'b1, 6'h0C, 32'h0000_0040, '0, '0, 5'h00);
    step(1'b1, 6'h0D, 32'hFFFF_FFF0, 32'h7, '0, 5'h00);
    step(1'b1, 6'h0E, 32'hFFFF_FFF0, 32'h7, '0, 5'h00);
    step(1'b1, 6'h12, 32'h3, 32'h4, '0, 5'h00);
    step(1'b1, 6'h13, 32'hFFFF_FFFF, 32'h1, '0, 5'h1F);
    step(1'b1, 6'h16, 32'h0, 32'h3, '0, 5'h01);
    step(1'b1, 6'h1A, 32'h3, 32'h0, 32'h4, 5'h00);
    step(1'b1, 6'h1F, 32'h1, 32'h1F, 32'h0, 5'h00);
    step(1'b0, 6'h00, '0, '0, '0, 5'h00);
    step(1'b0, 6'h00, '0, '0, '0, 5'h00);
    for (int i = 0; i < 64; i++) rstep(6'(i));
    for (int i = 0; i < 400; i++) begin
      rstep(6'(rnd % 34));
      if (rnd[3]) step(1'b0, 6'h00, '0, '0, '0, 5'h00);
    end
    step(1'b0, 6'h00, '0, '0, '0, 5'h00);
    arst_n = 1'b0;
    #1;
    check("reset result", result, CGA_RESULT_RST);
    check("reset valid", {31'h0, resultValid}, 32'h0);
    @(negedge clk_sys) arst_n = 1'b1;
    {expRes, expValid, expIll} = {CGA_RESULT_RST, 2'b00};
    step(1'b0, 6'h00, '0, '0, '0, 5'h00);
    end_of_test();
  end
endmodule
